// File: rtl/plsc_top.sv
// Loop feedback selection, detector suspend and shift clock gating
`default_nettype none
module plsc_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic referenceInput,
	input wire logic vcoClock,
	input wire logic refEdgeSelect,
	input wire logic dividerChainFeedbackSelect,
	input wire logic outsideFeedbackEnable,
	input wire logic outsideFeedbackInput,
	input wire logic outsideFeedbackEdgeSelect,
	input wire logic detectorSuspendEnable,
	input wire logic parallelVariant,
	input wire logic [3:0] parallelBusPins,
	input wire logic strobe,
	input wire logic blanking,
	input wire logic shiftClockGateEnable,
	input wire logic [3:0] loadClockDividerCode,
	input wire logic loadDividerWritten,
	input wire logic [8:0] secondaryDivider,
	input wire logic [1:0] postScalerSelect,
	input wire logic testDiffLevel,
	input wire logic testLoadLevel,
	input wire logic internalFeedbackPulse,
	output logic refEventPulse,
	output logic feedbackEventPulse,
	output logic detectorActive,
	output logic clockPlus,
	output logic clockMinus,
	output logic loadClockOut,
	output logic secondaryDividedOutput,
	output logic staticPinTestMode,
	output logic [3:0] latchedAddress
);
	// ==========================================
	// Edge detection and address capture
	logic refPrev_reg, fbPrev_reg, strobePrev_reg;
	logic [3:0] addr_reg, addr_next;
	logic [3:0] n1Code_reg, n1Code_next;
	function automatic logic pickEdge(input logic prev, input logic cur,
		input logic rising);
		pickEdge = rising ? (!prev && cur) : (prev && !cur);
	endfunction
	function automatic logic [4:0] n1Ratio(input logic [3:0] code);
		unique case (code[3] ? {2'b10, code[1:0]} : code)
			4'h0: n1Ratio = 5'h03;
			4'h1, 4'h2: n1Ratio = 5'h04;
			4'h3: n1Ratio = 5'h05;
			4'h4: n1Ratio = 5'h06;
			4'h5, 4'h6: n1Ratio = 5'h08;
			4'h7: n1Ratio = 5'h0A;
			4'h8: n1Ratio = 5'h0C;
			4'h9, 4'hA: n1Ratio = 5'h10;
			default: n1Ratio = 5'h14;
		endcase
	endfunction
	always_comb begin
		addr_next = addr_reg;
		if (strobePrev_reg && !strobe) begin
			addr_next = parallelBusPins; // R8
		end
		n1Code_next = loadDividerWritten ? loadClockDividerCode : n1Code_reg;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			refPrev_reg <= 1'b0;
			fbPrev_reg <= 1'b0;
			strobePrev_reg <= 1'b1;
			addr_reg <= 4'h0;
			n1Code_reg <= plsc_pkg::LOAD_DIV_RESET_CODE; // R19
		end else begin
			refPrev_reg <= referenceInput;
			fbPrev_reg <= outsideFeedbackInput;
			strobePrev_reg <= strobe;
			addr_reg <= addr_next;
			n1Code_reg <= n1Code_next;
		end
	end
	// ==========================================
	// Load clock and secondary divider
	logic loadTick, loadLevel;
	plsc_divider loadDiv (
		.clk(clk),
		.rst(rst),
		.ratio(n1Ratio(n1Code_reg)),
		.tick(loadTick),
		.level(loadLevel)
	);
	logic [8:0] secCount_reg, secCount_next;
	logic secLevel_reg, secLevel_next;
	logic gateOpen_reg, gateOpen_next;
	logic secRaw;
	always_comb begin
		secCount_next = secCount_reg;
		secLevel_next = secLevel_reg;
		if (loadTick) begin
			// Count 0 to modulus-1 so the chain divides by the modulus
			if (secCount_reg >= secondaryDivider - 9'h001) begin
				secCount_next = 9'h000;
			end else begin
				secCount_next = secCount_reg + 9'h001;
			end
			secLevel_next = (secCount_next < (secondaryDivider >> 1));
		end
		// Modulus one follows the load clock itself
		secRaw = (secondaryDivider <= 9'h001) ? loadLevel : secLevel_reg; // R13
		gateOpen_next = gateOpen_reg;
		if (!loadLevel) begin
			gateOpen_next = blanking; // R14 R15 R17
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			secCount_reg <= plsc_pkg::SEC_DIV_RESET;
			secLevel_reg <= 1'b0;
			gateOpen_reg <= 1'b0;
		end else begin
			secCount_reg <= secCount_next;
			secLevel_reg <= secLevel_next;
			gateOpen_reg <= gateOpen_next;
		end
	end
	// ==========================================
	// Phase detector inputs and output mux
	logic refEv_next, fbEv_next, active_next, test_next;
	logic plus_next, load_next, sec_next;
	logic chainEvent;
	plsc_pkg::plsc_mux_t mux;
	always_comb begin
		refEv_next = pickEdge(refPrev_reg, referenceInput, refEdgeSelect); // R1 R2
		chainEvent = loadTick && (secCount_reg == 9'h000);
		fbEv_next = internalFeedbackPulse;
		if (outsideFeedbackEnable) begin
			fbEv_next = pickEdge(fbPrev_reg, outsideFeedbackInput,
				!outsideFeedbackEdgeSelect); // R10 R11 R12
		end else if (dividerChainFeedbackSelect) begin
			fbEv_next = chainEvent; // R3
		end
		active_next = 1'b1; // R6
		if (detectorSuspendEnable) begin
			if (parallelVariant) begin
				active_next = !(addr_reg == plsc_pkg::SUSPEND_ADDR &&
					parallelBusPins[plsc_pkg::SUSPEND_BIT]); // R7
			end else begin
				active_next = !blanking; // R9
			end
		end
		test_next = (postScalerSelect == plsc_pkg::POST_TEST); // R24
		if (test_next) begin
			mux = plsc_pkg::PLSC_MUX_TEST;
		end else if (n1Code_reg == plsc_pkg::LOAD_DIV_RESET_CODE &&
			!loadDividerWritten && postScalerSelect == 2'h0) begin
			mux = plsc_pkg::PLSC_MUX_REF;
		end else begin
			mux = plsc_pkg::PLSC_MUX_VCO;
		end
		unique case (mux)
			plsc_pkg::PLSC_MUX_REF: plus_next = referenceInput; // R18
			plsc_pkg::PLSC_MUX_TEST: plus_next = testDiffLevel; // R25 R26
			default: plus_next = vcoClock;
		endcase
		load_next = test_next ? testLoadLevel : loadLevel; // R25
		sec_next = secRaw;
		if (shiftClockGateEnable && !gateOpen_next) begin
			sec_next = 1'b0; // R15
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			refEventPulse <= 1'b0;
			feedbackEventPulse <= 1'b0;
			detectorActive <= 1'b1;
			clockPlus <= 1'b0;
			clockMinus <= 1'b1;
			loadClockOut <= 1'b0;
			secondaryDividedOutput <= 1'b0;
			staticPinTestMode <= 1'b0;
			latchedAddress <= 4'h0;
		end else begin
			refEventPulse <= refEv_next && active_next;
			feedbackEventPulse <= fbEv_next && active_next;
			detectorActive <= active_next;
			clockPlus <= plus_next;
			clockMinus <= !plus_next; // R26
			loadClockOut <= load_next;
			secondaryDividedOutput <= sec_next; // R5
			staticPinTestMode <= test_next;
			latchedAddress <= addr_next;
		end
	end
	// ==========================================
	// Checks
	AST_SUSPEND: assert property (@(posedge clk) disable iff (rst)
		(detectorSuspendEnable && !parallelVariant && blanking)
		|=> !detectorActive) else $error("suspend missed"); // R9
	AST_PAR_SUSPEND: assert property (@(posedge clk) disable iff (rst)
		(detectorSuspendEnable && parallelVariant &&
		addr_reg == plsc_pkg::SUSPEND_ADDR &&
		parallelBusPins[plsc_pkg::SUSPEND_BIT]) |=> !detectorActive)
		else $error("bus suspend missed"); // R7
	AST_TEST_COMP: assert property (@(posedge clk) disable iff (rst)
		clockPlus != clockMinus) else $error("pair not complementary"); // R26
	AST_TEST_MODE: assert property (@(posedge clk) disable iff (rst)
		(postScalerSelect == 2'h3) |=> staticPinTestMode)
		else $error("test mode missed"); // R24
	AST_GATE_LOW: assert property (@(posedge clk) disable iff (rst)
		(shiftClockGateEnable && !gateOpen_next) |=> !secondaryDividedOutput)
		else $error("gated output high"); // R15
	AST_ADDR: assert property (@(posedge clk) disable iff (rst)
		(strobePrev_reg && !strobe) |=> latchedAddress == $past(parallelBusPins))
		else $error("address not latched"); // R8
endmodule
`default_nettype wire

// File: shared/plsc_pkg.sv
// Constants and types for the PLL loop and shift clock control block
// Functional notes
// [R1] Ref edge select 0: phase detector uses falling reference edges.
// [R2] Ref edge select 1: phase detector uses rising reference edges.
// [R3] Divider-chain select feeds load then secondary divider into detector.
// [R4] Programmer sets reference divider to one in divider-chain mode.
// [R5] Secondary divided output is driven on an external pin.
// [R6] Loop free-runs while detection suspended, relocks when suspension ends.
// [R7] Parallel variant: enable set, address 15, bus bit 3 high suspends.
// [R8] Parallel variant latches address from bus pins on strobe falling edge.
// [R9] Serial variant: enable set and blanking high suspends locking.
// [R10] Outside feedback enable selects outside feedback pin as feedback.
// [R11] Outside feedback edge select 0: rising feedback edges used.
// [R12] Outside feedback edge select 1: falling feedback edges used.
// [R13] Secondary modulus one makes secondary output copy load clock.
// [R14] Gate enabled, blanking high: secondary output runs in phase.
// [R15] Gate enabled, blanking low: secondary output stops low synchronously.
// [R16] Programmer never uses blanking for gating and suspension together.
// [R17] Gate start and stop only while load clock is low.
// [R18] Reset routes reference straight to differential outputs.
// [R19] Reset sets load clock divider modulus to four.
// [R20] Programmer waits 20 us after supply reaches 4 V.
// [R21] Programmer keeps VCO high using the post-scaler.
// [R22] Programmer picks lowest VCO gain for the target frequency.
// [R23] Programmer sets detector gain bits to 10 and high bit 1.
// [R24] Both post-scaler select bits 1 enters static pin test mode.
// [R25] In test mode two bits set differential and load pin levels.
// [R26] Test mode drives differential pair complementary.
`default_nettype none
package plsc_pkg;
	localparam logic [3:0] SUSPEND_ADDR = 4'hF;
	localparam int SUSPEND_BIT = 3;
	localparam logic [1:0] POST_TEST = 2'h3;
	localparam logic [3:0] LOAD_DIV_RESET_CODE = 4'h1;
	localparam logic [8:0] SEC_DIV_RESET = 9'h000;
	localparam logic [4:0] LOAD_DIV_RESET_RATIO = 5'h04;
	typedef enum logic [1:0] {
		PLSC_MUX_REF = 2'b00,
		PLSC_MUX_VCO = 2'b01,
		PLSC_MUX_TEST = 2'b10
	} plsc_mux_t;
endpackage
`default_nettype wire

// File: rtl/plsc_divider.sv
// Programmable counter divider producing a load clock enable and level
`default_nettype none
module plsc_divider (
	input wire logic clk,
	input wire logic rst,
	input wire logic [4:0] ratio,
	output logic tick,
	output logic level
);
	logic [4:0] countReg, countNext;
	logic levelReg, levelNext;
	always_comb begin
		countNext = countReg + 5'h01;
		levelNext = levelReg;
		if (countReg >= ratio - 5'h01) begin
			countNext = 5'h00;
		end
		levelNext = (countNext < (ratio >> 1));
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			countReg <= 5'h00;
			levelReg <= 1'b0;
		end else begin
			countReg <= countNext;
			levelReg <= levelNext;
		end
	end
	assign tick = (countReg == 5'h00);
	assign level = levelReg;
endmodule
`default_nettype wire

// File: verification/plsc_ref_model.sv
// Reference source and loop divider model facing the block
`default_nettype none
module plsc_ref_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic refLevel,
	input wire logic fbReq,
	output logic referenceInput,
	output logic vcoClock,
	output logic internalFeedbackPulse
);
	timeunit 1ns;
	timeprecision 1ps;
	logic fbLast;
	// ==========================================
	// Reference level, free clock, divider pulse
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			referenceInput <= 1'b0;
			vcoClock <= 1'b0;
			internalFeedbackPulse <= 1'b0;
			fbLast <= 1'b0;
		end else begin
			referenceInput <= refLevel;
			vcoClock <= ~vcoClock;
			internalFeedbackPulse <= fbReq ^ fbLast;
			fbLast <= fbReq;
		end
	end
endmodule
`default_nettype wire

// File: verification/plsc_top_tb.sv
// Self-checking bench for the loop and shift clock control block
`default_nettype none
module plsc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {int sel; logic [8:0] val;} plsc_exp_t;
	logic clk = 0, rst = 1, refLevel = 0, fbReq = 0, strobe = 1;
	logic refEdgeSelect = 0, dividerChainFeedbackSelect = 0, blanking = 0;
	logic outsideFeedbackEnable = 0, outsideFeedbackInput = 0;
	logic outsideFeedbackEdgeSelect = 0, detectorSuspendEnable = 0;
	logic parallelVariant = 0, shiftClockGateEnable = 0;
	logic loadDividerWritten = 0, testDiffLevel = 0, testLoadLevel = 0;
	logic [3:0] parallelBusPins = 4'h0, loadClockDividerCode = 4'h0;
	logic [8:0] secondaryDivider = 9'h000;
	logic [1:0] postScalerSelect = 2'h0;
	logic referenceInput, vcoClock, internalFeedbackPulse, refEventPulse;
	logic feedbackEventPulse, detectorActive, clockPlus, clockMinus;
	logic loadClockOut, secondaryDividedOutput, staticPinTestMode;
	logic [3:0] latchedAddress, a;
	logic clr = 0, smp = 0, lastL = 0, lastS = 0;
	int n_mismatch = 0, checks = 0, refN, fbN, loadN, secN;
	plsc_exp_t q[$];
	string nm[11] = '{"refEvents", "fbEvents", "loadRises", "secRises",
		"detectorActive", "clockPlus", "clockMinus", "loadClockOut",
		"secondaryOut", "testMode", "latchedAddress"};
	always #10 clk = ~clk;
	plsc_ref_model u_ref (.*);
	plsc_top u_dut (.*);
	// ==========================================
	// Monitor: counts edges, compares notes
	always @(posedge clk) begin : mon
		plsc_exp_t e;
		logic [8:0] s[11];
		s = '{9'(refN), 9'(fbN), 9'(loadN), 9'(secN), 9'(detectorActive),
			9'(clockPlus), 9'(clockMinus), 9'(loadClockOut),
			9'(secondaryDividedOutput), 9'(staticPinTestMode),
			9'(latchedAddress)};
		while (smp && q.size() > 0) begin
			e = q.pop_front();
			checks++;
			if (s[e.sel] !== e.val) begin
				n_mismatch++;
				$display("Error %s exp %0h seen %0h", nm[e.sel], e.val, s[e.sel]);
			end
		end
		refN <= clr ? 0 : refN + int'(refEventPulse);
		fbN <= clr ? 0 : fbN + int'(feedbackEventPulse);
		loadN <= clr ? 0 : loadN + int'(loadClockOut && !lastL);
		secN <= clr ? 0 : secN + int'(secondaryDividedOutput && !lastS);
		lastL <= loadClockOut;
		lastS <= secondaryDividedOutput;
	end
	// ==========================================
	// Driver tasks
	task automatic chk(input int sel, input logic [8:0] v);
		q.push_back('{sel, v});
	endtask
	task automatic win(input int n);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		repeat (n) @(posedge clk);
		smp <= 1'b1;
		@(posedge clk);
		smp <= 1'b0;
		@(posedge clk);
	endtask
	task automatic edge_t(input logic f, input logic p, input logic s);
		refEdgeSelect <= p;
		outsideFeedbackEdgeSelect <= p;
		if (f) outsideFeedbackInput <= s;
		else refLevel <= s;
		win(6);
		if (f) outsideFeedbackInput <= ~s;
		else refLevel <= ~s;
		chk(int'(f), 9'(f ? !(p ^ s) : p ^ s));
		win(6);
	endtask
	task automatic end_sim();
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// ==========================================
	// Main sequence
	initial begin
		void'($urandom(32'h7dcd));
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		win(4);
		refLevel <= 1'b1;
		win(4);
		chk(5, 9'h001);
		chk(6, 9'h000);
		chk(2, 9'h00A);
		win(40);
		outsideFeedbackEnable <= 1'b1;
		for (int k = 0; k < 8; k++) edge_t(k[2], k[1], k[0]);
		fbReq <= ~fbReq;
		chk(1, 9'h000);
		win(8);
		outsideFeedbackEnable <= 1'b0;
		fbReq <= ~fbReq;
		chk(1, 9'h001);
		win(8);
		dividerChainFeedbackSelect <= 1'b1;
		secondaryDivider <= 9'h001;
		win(8);
		chk(1, 9'h00A);
		win(40);
		dividerChainFeedbackSelect <= 1'b0;
		parallelVariant <= 1'b1;
		detectorSuspendEnable <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			a = (i == 0) ? 4'hF : 4'($urandom);
			parallelBusPins <= a;
			strobe <= 1'b1;
			win(2);
			strobe <= 1'b0;
			chk(10, 9'(a));
			win(4);
			parallelBusPins <= 4'h8;
			chk(4, 9'(a != 4'hF));
			win(4);
			parallelBusPins <= 4'h7;
			chk(4, 9'h001);
			win(4);
		end
		parallelVariant <= 1'b0;
		refEdgeSelect <= 1'b1;
		refLevel <= 1'b0;
		blanking <= 1'b1;
		chk(4, 9'h000);
		win(4);
		refLevel <= 1'b1;
		chk(0, 9'h000);
		win(6);
		blanking <= 1'b0;
		refEdgeSelect <= 1'b0;
		chk(4, 9'h001);
		win(4);
		refLevel <= 1'b0;
		chk(0, 9'h001);
		win(6);
		detectorSuspendEnable <= 1'b0;
		shiftClockGateEnable <= 1'b1;
		blanking <= 1'b1;
		win(8);
		chk(3, 9'h00A);
		win(40);
		blanking <= 1'b0;
		win(8);
		chk(3, 9'h000);
		chk(8, 9'h000);
		win(40);
		postScalerSelect <= 2'h3;
		for (int k = 0; k < 4; k++) begin
			testDiffLevel <= k[0];
			testLoadLevel <= k[1];
			win(4);
			chk(9, 9'h001);
			chk(5, 9'(k[0]));
			chk(6, 9'(!k[0]));
			chk(7, 9'(k[1]));
			win(2);
		end
		end_sim();
	end
endmodule
`default_nettype wire
